// ==== design/instr_exec_pkg.sv ====
// Package: encodings, field positions and carriers for the instruction group executor
package instr_exec_pkg;

  localparam int          INSTR_WIDTH   = 14;
  localparam int          DATA_WIDTH    = 8;
  localparam int          ADDR_WIDTH    = 7;
  localparam int          DEST_BIT      = 7;
  localparam int          ADDR_LSB      = 0;
  localparam int          LIT_LSB       = 0;
  localparam logic [5:0]  OPC_MOVE_REG  = 6'h08;
  localparam logic [5:0]  OPC_OR_REG    = 6'h04;
  localparam logic [5:0]  OPC_INC       = 6'h0A;
  localparam logic [5:0]  OPC_INC_SKIP  = 6'h0F;
  localparam logic [5:0]  OPC_STORE     = 6'h00;
  localparam logic [3:0]  OPC_LOAD_LIT  = 4'hC;
  localparam logic [5:0]  OPC_OR_LIT    = 6'h38;
  localparam logic [13:0] NOP_WORD      = 14'h0000;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic        ZERO_RESET    = 1'b0;

  typedef enum {
    op_none,
    op_increment_reg,
    op_increment_reg_skip_zero,
    op_or_literal_into_acc,
    op_or_acc_with_reg,
    op_move_reg,
    op_load_literal_acc,
    op_store_acc_to_reg
  } op_type;

  // Request to the file register array for one cycle
  typedef struct packed {
    logic                  write;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] data;
  } file_write_type;

endpackage : instr_exec_pkg

// ==== design/instr_classify.sv ====
// Classifier: maps a 14-bit instruction word onto the executed operation
`timescale 1ns/1ps
`default_nettype none
module instr_classify
  import instr_exec_pkg::*;
(
  // Instruction word
  input  wire logic [INSTR_WIDTH-1:0] instr,
  // Decoded operation
  output op_type                      op
);

  wire logic is_inc      = (instr[13:8] == OPC_INC);
  wire logic is_inc_skip = (instr[13:8] == OPC_INC_SKIP);
  wire logic is_or_reg   = (instr[13:8] == OPC_OR_REG);
  wire logic is_move     = (instr[13:8] == OPC_MOVE_REG);
  wire logic is_store    = (instr[13:8] == OPC_STORE) && instr[DEST_BIT];
  wire logic is_load     = (instr[13:10] == OPC_LOAD_LIT);
  wire logic is_or_lit   = (instr[13:8] == OPC_OR_LIT);

  // Anything else, the no-operation word included, changes no state
  assign op = is_inc      ? op_increment_reg :
              is_inc_skip ? op_increment_reg_skip_zero :
              is_or_reg   ? op_or_acc_with_reg :
              is_move     ? op_move_reg :
              is_store    ? op_store_acc_to_reg :
              is_load     ? op_load_literal_acc :
              is_or_lit   ? op_or_literal_into_acc :
                            op_none;

endmodule : instr_classify
`default_nettype wire

// ==== design/increment_or_move_instr_exec.sv ====
// Executor for the increment, inclusive-OR and move instruction group
// Summary of operation
// - Increment the file register at the 7-bit address and set zero from result.
// - Increment and register OR write to accumulator when dest 0, register when 1.
// - Increment-skip keeps zero flag; zero result replaces next instruction by no-op.
// - Literal OR combines accumulator with 8-bit literal into accumulator, sets zero.
// - Register OR combines accumulator and file register, routed by dest, sets zero.
// - Move-register copies file register to accumulator or itself, updates zero.
// - Moving a register onto itself still updates zero, a non-destructive test.
// - Load-literal puts 8-bit literal into accumulator, flags untouched, x bits ignored.
// - Store copies accumulator into the addressed file register, flags untouched.
// - The no-operation word changes no state besides program counter advance.
`timescale 1ns/1ps
`default_nettype none
module increment_or_move_instr_exec
  import instr_exec_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Fetch path
  input  wire logic                   instr_valid,
  input  wire logic [INSTR_WIDTH-1:0] instr,
  // File register read port, combinational from reg_addr
  output logic      [ADDR_WIDTH-1:0]  reg_addr,
  input  wire logic [DATA_WIDTH-1:0]  reg_rdata,
  // File register write port
  output file_write_type              reg_write,
  // Core state
  output logic      [DATA_WIDTH-1:0]  acc,
  output logic                        zero_flag,
  output logic                        skip_active,
  output logic                        pc_advance
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  op_type op;

  instr_classify classify
  (
    .instr (instr),
    .op    (op)
  );

  wire logic                  dest     = instr[DEST_BIT];
  wire logic [DATA_WIDTH-1:0] literal  = instr[LIT_LSB +: DATA_WIDTH];
  wire logic [DATA_WIDTH-1:0] inc_val  = reg_rdata + 8'h01;
  wire logic [DATA_WIDTH-1:0] or_reg   = acc | reg_rdata;
  wire logic [DATA_WIDTH-1:0] or_lit   = acc | literal;
  // A skipped slot executes as the no-operation word, whatever was fetched
  wire logic                  live     = instr_valid && !skip_active;

  ////////////////////////////////////////////////////////////////////////////////
  // Result selection

  logic [DATA_WIDTH-1:0] result;
  logic                  to_reg;
  logic                  to_acc;
  logic                  sets_zero;
  logic                  next_skip;

  always_comb
  begin
    result    = ACC_RESET;
    to_reg    = 1'b0;
    to_acc    = 1'b0;
    sets_zero = 1'b0;
    next_skip = 1'b0;
    if (live)
    begin
      case (op)
        op_increment_reg:
        begin
          result    = inc_val;
          to_reg    = dest;
          to_acc    = !dest;
          sets_zero = 1'b1;
        end
        op_increment_reg_skip_zero:
        begin
          result    = inc_val;
          to_reg    = dest;
          to_acc    = !dest;
          next_skip = (inc_val == 8'h00);
        end
        op_or_acc_with_reg:
        begin
          result    = or_reg;
          to_reg    = dest;
          to_acc    = !dest;
          sets_zero = 1'b1;
        end
        op_or_literal_into_acc:
        begin
          result    = or_lit;
          to_acc    = 1'b1;
          sets_zero = 1'b1;
        end
        op_move_reg:
        begin
          result    = reg_rdata;
          to_reg    = dest;
          to_acc    = !dest;
          sets_zero = 1'b1;
        end
        op_load_literal_acc:
        begin
          result    = literal;
          to_acc    = 1'b1;
        end
        op_store_acc_to_reg:
        begin
          result    = acc;
          to_reg    = 1'b1;
        end
        default:
        begin
          result    = ACC_RESET;
        end
      endcase
    end
  end

  wire logic next_zero = (result == 8'h00);

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs toward the register array

  assign reg_addr = instr[ADDR_LSB +: ADDR_WIDTH];

  // Idle write carrier is all zero, so stale address or data never leaks
  wire file_write_type next_write = to_reg ?
    file_write_type'{write: 1'b1, addr: reg_addr, data: result} : '0;

  // Registered write: file array sees the write one cycle after execute
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      reg_write <= '0;
    else
      reg_write <= next_write;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core state

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      acc         <= ACC_RESET;
      zero_flag   <= ZERO_RESET;
      skip_active <= 1'b0;
      pc_advance  <= 1'b0;
    end
    else
    begin
      if (to_acc)
        acc <= result;
      if (sets_zero)
        zero_flag <= next_zero;
      // Skip lasts until the next valid slot, which it cancels; bubbles before it do not clear it
      if (instr_valid)
        skip_active <= next_skip;
      pc_advance <= instr_valid;
    end
  end

endmodule : increment_or_move_instr_exec
`default_nettype wire

// ==== dv/file_reg_model.sv ====
// Behavioural file register array on the far side
`timescale 1ns/1ps
`default_nettype none
module file_reg_model
  import instr_exec_pkg::*;
(
  // Clock
  input  wire logic                  clock,
  // Read and write ports
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  output logic      [DATA_WIDTH-1:0] reg_rdata,
  input  wire file_write_type        reg_write
);
  logic [DATA_WIDTH-1:0] mem [128];
  // Read is combinational, as the executor samples it in the same cycle
  assign reg_rdata = mem[reg_addr];
  always @(posedge clock)
  begin
    if (reg_write.write)
      mem[reg_write.addr] <= reg_write.data;
  end
endmodule : file_reg_model
`default_nettype wire

// ==== dv/increment_or_move_instr_exec_props.sv ====
// Port-level checks on the instruction group executor
`timescale 1ns/1ps
`default_nettype none
module increment_or_move_instr_exec_props
  import instr_exec_pkg::*;
(
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   rst,
  // Watched ports
  input wire logic                   instr_valid,
  input wire logic [INSTR_WIDTH-1:0] instr,
  input wire logic [ADDR_WIDTH-1:0]  reg_addr,
  input wire logic [DATA_WIDTH-1:0]  reg_rdata,
  input wire file_write_type         reg_write,
  input wire logic [DATA_WIDTH-1:0]  acc,
  input wire logic                   zero_flag,
  input wire logic                   skip_active,
  input wire logic                   pc_advance
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire       exe = instr_valid && !skip_active;
  wire [5:0] opc = instr[13:8];
  sequence s_zero_skip;
    exe && opc == OPC_INC_SKIP && reg_rdata == 8'hFF;
  endsequence
  sequence s_inc(bit dst);
    exe && opc == OPC_INC && instr[DEST_BIT] == dst;
  endsequence
  AST_ADDR:
    assert property (reg_addr == instr[6:0]) else $error("bad address");
  AST_INC_REG:
    assert property (s_inc(1) |=> reg_write.write && reg_write.data == $past(reg_rdata) + 8'h01
      && zero_flag == (reg_write.data == 8'h00)) else $error("bad increment");
  AST_INC_ACC:
    assert property (s_inc(0) |=> acc == $past(reg_rdata) + 8'h01 && !reg_write.write)
      else $error("bad increment to acc");
  AST_SKIP:
    assert property (s_zero_skip |=> skip_active && $stable(zero_flag)) else $error("no skip");
  AST_SKIP_SLOT:
    assert property (s_zero_skip ##1 instr_valid |=> !skip_active && !reg_write.write
      && $stable(acc)) else $error("skip slot not idle");
  AST_OR_LIT:
    assert property (exe && opc == OPC_OR_LIT |=> acc == $past(acc | instr[7:0])
      && zero_flag == (acc == 8'h00)) else $error("bad literal or");
  AST_OR_REG:
    assert property (exe && opc == OPC_OR_REG && instr[DEST_BIT] |=>
      reg_write.data == $past(acc | reg_rdata)) else $error("bad register or");
  AST_MOVE:
    assert property (exe && opc == OPC_MOVE_REG |=> zero_flag == ($past(reg_rdata) == 8'h00))
      else $error("bad move zero");
  AST_LOAD:
    assert property (exe && instr[13:10] == OPC_LOAD_LIT |=> acc == $past(instr[7:0])
      && $stable(zero_flag)) else $error("bad load");
  AST_STORE:
    assert property (exe && instr[13:7] == {OPC_STORE, 1'b1} |=> reg_write ==
      {1'b1, $past(instr[6:0]), $past(acc)} && $stable(zero_flag)) else $error("bad store");
  AST_PC_STEP:
    assert property ($past(!rst) |-> pc_advance == $past(instr_valid)) else $error("bad step");
endmodule : increment_or_move_instr_exec_props
bind increment_or_move_instr_exec increment_or_move_instr_exec_props props (.clock, .rst,
  .instr_valid, .instr, .reg_addr, .reg_rdata, .reg_write, .acc, .zero_flag, .skip_active,
  .pc_advance);
`default_nettype wire

// ==== dv/increment_or_move_instr_exec_tb_top.sv ====
// Self-checking testbench for the instruction group executor
`timescale 1ns/1ps
`default_nettype none
module increment_or_move_instr_exec_tb_top;
  import instr_exec_pkg::*;
  logic                   clock = 1'b0;
  logic                   rst = 1'b1;
  logic                   instr_valid = 1'b0;
  logic [INSTR_WIDTH-1:0] instr = 14'h0000;
  logic [ADDR_WIDTH-1:0]  reg_addr;
  logic [DATA_WIDTH-1:0]  reg_rdata;
  logic [DATA_WIDTH-1:0]  acc;
  file_write_type         reg_write;
  logic                   zero_flag;
  logic                   skip_active;
  logic                   pc_advance;
  int                     mismatches = 0;
  int                     samples_checked = 0;
  always #5 clock = ~clock;
  increment_or_move_instr_exec uut (.clock, .rst, .instr_valid, .instr, .reg_addr, .reg_rdata,
    .reg_write, .acc, .zero_flag, .skip_active, .pc_advance);
  file_reg_model fr (.clock, .reg_addr, .reg_rdata, .reg_write);
  ////////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Valid stays high so back-to-back calls never toggle it twice
  task run(input logic [13:0] w);
    instr = w;
    instr_valid = 1'b1;
    @(posedge clock);
    #1;
  endtask : run
  task chk(input logic [7:0] a, input logic z, input logic s, input logic [15:0] w);
    samples_checked++;
    if ({acc, zero_flag, skip_active, pc_advance, reg_write} !== {a, z, s, 1'b1, w})
    begin
      mismatches++;
      $display("unexpected at %0t: acc %h z %b skip %b wr %h", $time, acc, zero_flag,
        skip_active, reg_write);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    @(posedge clock);
    #1;
    fr.mem[5] = 8'hFF;
    fr.mem[6] = 8'h41;
    fr.mem[9] = 8'h0F;
    fr.mem[10] = 8'h00;
    fr.mem[11] = 8'h33;
    fr.mem[7] = 8'hFF;
    fr.mem[8] = 8'h10;
    run(14'h0A85);
    chk(8'h00, 1'b1, 1'b0, 16'h8500);
    run(14'h0A06);
    chk(8'h42, 1'b0, 1'b0, 16'h0000);
    run(14'h3000);
    run(14'h3800);
    chk(8'h00, 1'b1, 1'b0, 16'h0000);
    run(14'h33A5);
    chk(8'hA5, 1'b1, 1'b0, 16'h0000);
    run(14'h385A);
    chk(8'hFF, 1'b0, 1'b0, 16'h0000);
    run(14'h0489);
    chk(8'hFF, 1'b0, 1'b0, 16'h89FF);
    run(14'h088A);
    chk(8'hFF, 1'b1, 1'b0, 16'h8A00);
    run(14'h080B);
    chk(8'h33, 1'b0, 1'b0, 16'h0000);
    run(14'h008C);
    chk(8'h33, 1'b0, 1'b0, 16'h8C33);
    run(14'h0060);
    chk(8'h33, 1'b0, 1'b0, 16'h0000);
    run(14'h0F07);
    chk(8'h00, 1'b0, 1'b1, 16'h0000);
    run(14'h3055);
    chk(8'h00, 1'b0, 1'b0, 16'h0000);
    run(14'h0F08);
    chk(8'h11, 1'b0, 1'b0, 16'h0000);
    run(14'h0F87);
    chk(8'h11, 1'b0, 1'b1, 16'h8700);
    // A bubble must leave the pending skip in place
    instr_valid = 1'b0;
    @(posedge clock);
    #1;
    run(14'h0A06);
    chk(8'h11, 1'b0, 1'b0, 16'h0000);
    run(14'h0409);
    chk(8'hFF, 1'b0, 1'b0, 16'h0000);
    instr_valid = 1'b0;
    summarize;
  end
  initial
  begin
    #5000;
    mismatches++;
    summarize;
  end
endmodule : increment_or_move_instr_exec_tb_top
`default_nettype wire
